// *** design/pidv_map.vh ***
// register offsets, field positions and reset values of the paged id/vendor block
`ifndef PIDV_MAP_VH
`define PIDV_MAP_VH
// page selector values
`define PIDV_PAGE_IDENT 3'h1
`define PIDV_PAGE_VENDOR 3'h7
// paged offsets, identification page
`define PIDV_OFF_COMPLIANCE 4'h8
`define PIDV_OFF_OUI_HIGH 4'hA
`define PIDV_OFF_OUI_MID 4'hB
`define PIDV_OFF_OUI_LOW 4'hC
`define PIDV_OFF_PART_HIGH 4'hD
`define PIDV_OFF_PART_MID 4'hE
`define PIDV_OFF_PART_LOW 4'hF
// paged offsets, vendor-dependent page
`define PIDV_OFF_SPECIAL 4'h8
`define PIDV_OFF_SOFT_RESET 4'hE
// base register holding the page selector, and its field (low three bits)
`define PIDV_OFF_PAGE_SEL 4'h7
// field positions as bus bit numbers (doc bit 0 is bus bit 7)
`define PIDV_BIT_NULL_KEEP 7
`define PIDV_BIT_SPEED_HI 1
`define PIDV_BIT_SPEED_LO 0
`define PIDV_BIT_SOFT_RESET 7
// reset and constant values
`define PIDV_COMPLIANCE_VAL 8'h01
`define PIDV_SPEED_RST 2'h2
`define PIDV_NULL_KEEP_RST 1'h0
`define PIDV_PAGE_RST 3'h0
`define PIDV_PHY_SPEED 2'h2
`endif

// *** design/pidv_regs.v ***
// paged identification and vendor-dependent register bank of a serial-bus phy
// Contract
// R1: page 1 maps identification registers
// R2: page 7 maps control/test registers
// R3: compliance byte 01h at address 8
// R4: 24-bit maker id, msb at 1010b
// R5: 24-bit part_identifier, msb at 1101b
// R6: null policy applies only with acceleration
// R7: policy one: clear only on >8-bit packets
// R8: policy zero: clear on any non-ack
// R9: policy bit zero at hard reset
// R10: two-bit link speed field, read/write
// R11: speed field copied into self-id
// R12: always signal 400 to peers
// R13: speed resets to 10b, bus reset keeps
// R14: writing one does full hard reset
// R15: soft reset bit reads zero
// R16: soft reset bit at 1110b bit 0
// R17: reserved bits read zero, ignore writes
// R18: doc bit 0 is the msb
//
// The strobed register port was left to the implementer.
`timescale 1ns/100ps
`include "pidv_map.vh"

module pidv_regs #(
    parameter [23:0] MAKER_OUI = 24'h123456,       // arbitrary value
    parameter [23:0] PART_IDENTIFIER = 24'hABCDEF, // arbitrary value
    parameter integer RST_PULSE = 4                // soft reset pulse lasts this many cycles plus one
) (
    input wire mclk_i,              // 125 MHz clock
    input wire rst_n_i,             // async reset, active low
    input wire [3:0] addr_i,        // register address
    input wire [7:0] wdata_i,       // write data
    input wire wr_i,                // write strobe
    input wire rd_i,                // read strobe
    input wire accel_en_i,          // arbitration acceleration enabled
    input wire pkt_end_i,           // received packet ended, pulse
    input wire [15:0] pkt_bits_i,   // data bits in received packet
    output reg [7:0] rdata_o,       // read data, one cycle after rd
    output reg [2:0] page_sel_o,    // current page selector
    output reg [1:0] selfid_speed_subfield_o, // speed into self-id
    output reg [1:0] peer_speed_o,  // speed signaled to peer phys
    output reg null_packet_keep_requests_o, // policy bit state
    output reg clear_requests_o,    // clear fair/priority requests, pulse
    output reg hard_reset_o         // full hard reset request, level
);

    reg [2:0] page_q;
    reg null_keep_q;
    reg [1:0] speed_q;
    reg [7:0] rdata_d;
    reg [2:0] rst_cnt_q;
    reg swr_q;
    reg [1:0] swr_sync_q;
    wire int_rst_n;
    wire is_ack;
    wire long_pkt;
    wire clr_d;

    // internal reset: external pin or soft reset pulse
    assign int_rst_n = rst_n_i & ~swr_sync_q[1];

    // soft reset pulse generator, only on external reset
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_cnt_q <= 3'h0;
            swr_q <= 1'b0;
        end else if (wr_i && page_q == `PIDV_PAGE_VENDOR &&
                     addr_i == `PIDV_OFF_SOFT_RESET && wdata_i[`PIDV_BIT_SOFT_RESET]) begin
            // R14: start hard reset
            swr_q <= 1'b1;
            rst_cnt_q <= RST_PULSE[2:0];
        end else if (rst_cnt_q != 3'h0) begin
            rst_cnt_q <= rst_cnt_q - 3'h1;
        end else begin
            swr_q <= 1'b0;
        end
    end

    // registered reset pulse so internal reset is glitch free
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            swr_sync_q <= 2'h0;
        end else begin
            swr_sync_q <= {swr_sync_q[0], swr_q};
        end
    end

    // register writes
    always @(posedge mclk_i or negedge int_rst_n) begin
        if (!int_rst_n) begin
            page_q <= `PIDV_PAGE_RST;
            // R9: policy cleared at hard reset
            null_keep_q <= `PIDV_NULL_KEEP_RST;
            // R13: 400 after hard reset
            speed_q <= `PIDV_SPEED_RST;
        end else if (wr_i) begin
            if (addr_i == `PIDV_OFF_PAGE_SEL) begin
                page_q <= wdata_i[2:0];
            end
            // R2: control register writes on page 7
            if (page_q == `PIDV_PAGE_VENDOR && addr_i == `PIDV_OFF_SPECIAL) begin
                null_keep_q <= wdata_i[`PIDV_BIT_NULL_KEEP];
                // R10: R18: speed from doc bits 6..7
                speed_q <= {wdata_i[`PIDV_BIT_SPEED_HI], wdata_i[`PIDV_BIT_SPEED_LO]};
            end
        end
    end

    // read mux
    always @* begin
        rdata_d = 8'h00;
        if (addr_i == `PIDV_OFF_PAGE_SEL) begin
            rdata_d = {5'h00, page_q};
        end else if (page_q == `PIDV_PAGE_IDENT) begin
            // R1: identification page mapping
            case (addr_i)
                // R3: compliance level
                `PIDV_OFF_COMPLIANCE: rdata_d = `PIDV_COMPLIANCE_VAL;
                // R4: maker id, msb first
                `PIDV_OFF_OUI_HIGH: rdata_d = MAKER_OUI[23:16];
                `PIDV_OFF_OUI_MID: rdata_d = MAKER_OUI[15:8];
                `PIDV_OFF_OUI_LOW: rdata_d = MAKER_OUI[7:0];
                // R5: part_identifier, msb first
                `PIDV_OFF_PART_HIGH: rdata_d = PART_IDENTIFIER[23:16];
                `PIDV_OFF_PART_MID: rdata_d = PART_IDENTIFIER[15:8];
                `PIDV_OFF_PART_LOW: rdata_d = PART_IDENTIFIER[7:0];
                // R17: reserved reads zero
                default: rdata_d = 8'h00;
            endcase
        end else if (page_q == `PIDV_PAGE_VENDOR) begin
            case (addr_i)
                // R18: policy in msb, speed in low bits
                `PIDV_OFF_SPECIAL: rdata_d = {null_keep_q, 5'h00, speed_q};
                // R15: R16: soft reset bit reads zero
                `PIDV_OFF_SOFT_RESET: rdata_d = 8'h00;
                // R17: test bytes read zero
                default: rdata_d = 8'h00;
            endcase
        end
    end

    // packet classification
    assign is_ack = (pkt_bits_i == 16'h0008);
    assign long_pkt = (pkt_bits_i > 16'h0008);
    // R6: R7: R8: request clearing policy
    assign clr_d = pkt_end_i & ((accel_en_i & null_keep_q) ? long_pkt : ~is_ack);

    // registered outputs
    always @(posedge mclk_i or negedge int_rst_n) begin
        if (!int_rst_n) begin
            rdata_o <= 8'h00;
            page_sel_o <= `PIDV_PAGE_RST;
            selfid_speed_subfield_o <= `PIDV_SPEED_RST;
            peer_speed_o <= `PIDV_PHY_SPEED;
            null_packet_keep_requests_o <= `PIDV_NULL_KEEP_RST;
            clear_requests_o <= 1'b0;
        end else begin
            rdata_o <= rd_i ? rdata_d : 8'h00;
            page_sel_o <= page_q;
            // R11: speed into self-id
            selfid_speed_subfield_o <= speed_q;
            // R12: peers always see 400
            peer_speed_o <= `PIDV_PHY_SPEED;
            null_packet_keep_requests_o <= null_keep_q;
            clear_requests_o <= clr_d;
        end
    end

    // hard reset indication to the rest of the phy
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hard_reset_o <= 1'b1;
        end else begin
            // R14: stretched hard reset out
            hard_reset_o <= swr_sync_q[1];
        end
    end

endmodule // pidv_regs

// *** tb/pidv_pkt_src.sv ***
// far side model feeding end-of-packet events
`timescale 1ns/100ps
module pidv_pkt_src (
    input wire mclk_i, // clock
    input wire go_i, // send one packet
    input wire [15:0] n_i, // its bit count
    output reg pkt_end_o = 1'b0, // packet ended
    output reg [15:0] pkt_bits_o = 16'hA5A5 // bit count
);
    // count valid with end only, scrambled otherwise
    always @(posedge mclk_i) begin
        pkt_end_o <= go_i;
        pkt_bits_o <= go_i ? n_i : ~pkt_bits_o;
    end
endmodule // pidv_pkt_src

// *** tb/pidv_regs_asserts.sv ***
// assertions on the paged id and vendor bank ports
`timescale 1ns/100ps
module pidv_regs_asserts (
    input wire mclk_i, // clock
    input wire rst_n_i, // reset
    input wire [3:0] addr_i, // address
    input wire [7:0] wdata_i, // write data
    input wire wr_i, // write
    input wire rd_i, // read
    input wire accel_en_i, // acceleration
    input wire pkt_end_i, // packet end
    input wire [15:0] pkt_bits_i, // bit count
    input wire [7:0] rdata_o, // read data
    input wire [2:0] page_sel_o, // page
    input wire [1:0] selfid_speed_subfield_o, // speed
    input wire [1:0] peer_speed_o, // peer speed
    input wire null_packet_keep_requests_o, // policy
    input wire clear_requests_o, // clear
    input wire hard_reset_o // hard reset
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    // vendor page write and short packet end helpers
    wire wv = wr_i && page_sel_o == 3'h7;
    wire pe = pkt_end_i && pkt_bits_i < 16'h0008;
    sequence s_swr;
        wv && addr_i == 4'hE && wdata_i[7];
    endsequence
    a_peer_fixed: assert property (peer_speed_o == 2'h2)
        else $error("peer speed not 400");
    a_page_load: assert property (wr_i && addr_i == 4'h7
        |=> ##1 page_sel_o == $past(wdata_i[2:0], 2)) else $error("page not loaded");
    a_speed_copy: assert property (wv && addr_i == 4'h8
        |=> ##1 selfid_speed_subfield_o == $past(wdata_i[1:0], 2)) else $error("speed");
    a_rdata_idle: assert property (!rd_i |=> rdata_o == 8'h00)
        else $error("read data without read");
    a_hreset_ends: assert property (s_swr |-> ##[8:12] !hard_reset_o)
        else $error("hard reset stuck");
    a_ack_keeps: assert property (pkt_end_i && pkt_bits_i == 16'h0008
        |=> !clear_requests_o) else $error("ack cleared");
    a_long_clears: assert property (pkt_end_i && pkt_bits_i > 16'h0008
        |=> clear_requests_o) else $error("long packet kept");
    a_short_keep: assert property (pe && accel_en_i && null_packet_keep_requests_o
        |=> !clear_requests_o) else $error("short packet cleared");
    a_short_clear: assert property (pe && !(accel_en_i && null_packet_keep_requests_o)
        |=> clear_requests_o) else $error("short packet kept");
    a_swr_reads: assert property (rd_i && page_sel_o == 3'h7 && addr_i == 4'hE
        |=> !rdata_o[7]) else $error("soft reset bit read one");
    a_swr_pulse: assert property (s_swr |-> ##[2:5] hard_reset_o)
        else $error("no hard reset");
endmodule // pidv_regs_asserts
bind pidv_regs pidv_regs_asserts pidv_regs_asserts_inst (.*);

// *** tb/pidv_regs_tb.sv ***
// self-checking bench of the paged id and vendor bank
`timescale 1ns/100ps
module pidv_regs_tb;
    reg mclk_i = 0, rst_n_i = 0, wr_i = 0, rd_i = 0, accel_en_i = 0, go = 0, rs = 0;
    reg [3:0] addr_i = 4'h0;
    reg [7:0] wdata_i = 8'h00;
    reg [15:0] n = 16'h0000, b;
    reg [31:0] seed = 32'h388B9ABF;
    wire [7:0] rdata_o;
    wire [2:0] page_sel_o;
    wire [1:0] selfid_speed_subfield_o, peer_speed_o;
    wire null_packet_keep_requests_o, clear_requests_o, hard_reset_o, pkt_end_i;
    wire [15:0] pkt_bits_i;
    logic [7:0] q[$];
    integer errors = 0, comparisons = 0, cyc = 0, i, j;
    // identifiers are arbitrary values
    pidv_regs #(.MAKER_OUI(24'h5A1C33), .PART_IDENTIFIER(24'h0C7E91)) pidv_regs_inst (.*);
    pidv_pkt_src pidv_pkt_src_inst (.mclk_i(mclk_i), .go_i(go), .n_i(n),
        .pkt_end_o(pkt_end_i), .pkt_bits_o(pkt_bits_i));
    function [31:0] lfsr(input [31:0] x);
        lfsr = {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h00000000);
    endfunction
    task check(input string w, input [7:0] s, input [7:0] e);
        comparisons = comparisons + 1;
        if (s !== e) begin
            errors = errors + 1;
            $display("MISMATCH %s expected %h seen %h", w, e, s);
        end
    endtask
    task wr(input [3:0] a, input [7:0] d);
        @(posedge mclk_i) {wr_i, addr_i, wdata_i} <= {1'b1, a, d};
        @(posedge mclk_i) wr_i <= 1'b0;
    endtask
    task rd(input [3:0] a, input [7:0] e);
        q.push_back(e);
        @(posedge mclk_i) {rd_i, addr_i} <= {1'b1, a};
        @(posedge mclk_i) rd_i <= 1'b0;
    endtask
    task pkt(input [15:0] c, input e);
        @(posedge mclk_i) {go, n} <= {1'b1, c};
        @(posedge mclk_i) go <= 1'b0;
        @(posedge mclk_i) #1 check("clear", clear_requests_o, e);
    endtask
    task report_and_stop;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // clock, timeout, read data watcher
    initial forever #4 mclk_i = ~mclk_i;
    always @(posedge mclk_i) begin
        cyc = cyc + 1;
        if (rs) check("rdata", rdata_o, q.pop_front());
        rs = rd_i;
        if (cyc == 3000) begin
            errors = errors + 1;
            report_and_stop;
        end
    end
    initial begin
        repeat (8) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        wr(4'h7, 8'h01);
        rd(4'h8, 8'h01);
        rd(4'h9, 8'h00);
        for (i = 0; i < 6; i = i + 1) rd(4'hA + i, 48'h5A1C330C7E91 >> (40 - 8 * i));
        wr(4'h7, 8'h07);
        rd(4'h8, 8'h02);
        rd(4'hE, 8'h00);
        for (i = 0; i < 4; i = i + 1) begin
            seed = lfsr(seed);
            wr(4'h8, {seed[7:2], i[1:0]});
            rd(4'h8, {seed[7], 5'h00, i[1:0]});
            check("speed", selfid_speed_subfield_o, i[1:0]);
        end
        for (j = 0; j < 4; j = j + 1) begin
            accel_en_i <= j[1];
            wr(4'h8, {j[0], 7'h01});
            for (i = 0; i < 5; i = i + 1) begin
                seed = lfsr(seed);
                b = i < 4 ? 64'h0009000800050000 >> (16 * i) : 16'h0009 + seed[11:0];
                pkt(b, b != 16'h0008 && !(j == 3 && b < 16'h0008));
            end
        end
        wr(4'hE, 8'h7F);
        repeat (6) @(posedge mclk_i);
        check("hreset", hard_reset_o, 8'h00);
        wr(4'hE, 8'h80);
        repeat (3) @(posedge mclk_i);
        #1 check("hreset", hard_reset_o, 8'h01);
        repeat (17) @(posedge mclk_i);
        rd(4'h7, 8'h00);
        check("speed", selfid_speed_subfield_o, 8'h02);
        check("policy", null_packet_keep_requests_o, 8'h00);
        check("peer", peer_speed_o, 8'h02);
        repeat (2) @(posedge mclk_i);
        report_and_stop;
    end
endmodule // pidv_regs_tb
